// *** core/tpu_cc_pkg.sv ***
// constants of the timer compare/capture core: offsets, fields, resets
// assumes a 16-bit plain register port and synchronous pin inputs
// Operation
// - reg-d compare match drives off/0/1/toggle
// - output setup loads initial pin level
// - code 1000 captures on pin rise
// - code 1001 captures on pin fall
// - code 101x captures on both edges
// - code 11xx captures on channel-1 counts
// - no channel-1 capture with undivided prescale
// - buffer mode blocks capture and compare
// - pwm mode 1 routes to pin c
// - six readable writable 16-bit counters
// - counters clear on reset and standby
// - general registers 16-bit, reset all ones
// - sixteen general registers across six channels
// - channels 0/3: c pairs a, d pairs b; the core pairs none, channel 0 buffer mode only blocks reg d
package tpu_cc_pkg;
    localparam int CNT_W  = 16;
    localparam int NUM_CH = 6;
    localparam int NUM_GR = 16;
    localparam int ADDR_W = 8;
    localparam int PSC_W  = 3;
    // register offsets (word addresses on the plain port)
    localparam logic [7:0] OFS_IO_CTRL  = 8'h00;
    localparam logic [7:0] OFS_MODE     = 8'h01;
    localparam logic [7:0] OFS_CH1_CTRL = 8'h02;
    localparam logic [7:0] OFS_STATUS   = 8'h03;
    localparam logic [7:0] OFS_CNT_BASE = 8'h10;
    localparam logic [7:0] OFS_CNT_END  = 8'h16;
    localparam logic [7:0] OFS_GR_BASE  = 8'h20;
    localparam logic [7:0] OFS_GR_END   = 8'h30;
    // general register index of channel 0 register d
    localparam int GR_D0 = 3;
    // io control field positions
    localparam int IOD_CAP = 7;
    localparam int IOD_LVL = 6;
    localparam int IOD_HI  = 7;
    localparam int IOD_LO  = 4;
    // mode register bits
    localparam int MODE_BUF_D = 0;
    localparam int MODE_PWM1  = 1;
    // status bits
    localparam int STS_LVL  = 0;
    localparam int STS_D_OE = 1;
    localparam int STS_C_OE = 2;
    // compare actions, low two bits of the field
    localparam logic [1:0] ACT_OFF  = 2'h0;
    localparam logic [1:0] ACT_LOW  = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOG  = 2'h3;
    // capture source, bits 7:6 of the field
    localparam logic [1:0] SRC_PIN = 2'h2;
    localparam logic [1:0] SRC_CH1 = 2'h3;
    localparam logic [PSC_W-1:0] PSC_UNDIV = 3'h0;
    // reset values
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] GR_RST  = 16'hffff;
    localparam logic [7:0]  IO_RST  = 8'h00;
    localparam logic [PSC_W-1:0] PSC_RST = 3'h0;
endpackage : tpu_cc_pkg

// *** core/chan_counter.sv ***
// one channel up/down counter with load and clear
// assumes tick, load and clear are one-cycle synchronous pulses
`timescale 1ns/1ps
`default_nettype none
module chan_counter #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic         ce_i,
    // control
    input  wire logic         clear_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    input  wire logic         tick_i,
    input  wire logic         down_i,
    // count
    output logic      [W-1:0] cnt_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } cnt_state_type;

    cnt_state_type s_reg;
    cnt_state_type s_next;

    always_comb begin
        s_next = s_reg;
        if (clear_i) begin
            s_next.cnt = '0;
        end else if (load_i) begin
            s_next.cnt = load_val_i;
        end else if (tick_i) begin
            s_next.cnt = down_i ? s_reg.cnt - W'(1) : s_reg.cnt + W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_reg <= '0;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    assign cnt_o = s_reg.cnt;
endmodule : chan_counter
`default_nettype wire

// *** core/pin_edge.sv ***
// rising and falling edge detector for a synchronous pin input
// assumes the pin is already synchronous to the clock
`timescale 1ns/1ps
`default_nettype none
module pin_edge (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    // pin and edges
    input  wire logic pin_i,
    output logic      rise_o,
    output logic      fall_o
);
    typedef struct packed {
        logic prev;
    } edge_state_type;

    edge_state_type s_reg;
    edge_state_type s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.prev = pin_i;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_reg <= '0;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    assign rise_o = pin_i & ~s_reg.prev;
    assign fall_o = ~pin_i & s_reg.prev;
endmodule : pin_edge
`default_nettype wire

// *** core/timer_pulse_core.sv ***
// six-channel counters, sixteen general registers, channel 0 reg d i/o
// assumes strobes one cycle long, synchronous pins, external count ticks
`timescale 1ns/1ps
`default_nettype none
module timer_pulse_core (
    // clock, reset, enable
    input  wire logic                                SYS_CLK_I,
    input  wire logic                                NRST_I,
    input  wire logic                                CE_I,
    input  wire logic                                STANDBY_I,
    // register port
    input  wire logic [tpu_cc_pkg::ADDR_W-1:0]       ADDR_I,
    input  wire logic [15:0]                         WDATA_I,
    input  wire logic                                WR_I,
    input  wire logic                                RD_I,
    output logic      [15:0]                         RDATA_O,
    // count ticks from the prescalers
    input  wire logic [tpu_cc_pkg::NUM_CH-1:0]       COUNT_TICK_I,
    input  wire logic [tpu_cc_pkg::NUM_CH-1:0]       COUNT_DOWN_I,
    // channel 0 pins
    input  wire logic                                PIN_D_I,
    output logic                                     PIN_D_O,
    output logic                                     PIN_D_OE_O,
    output logic                                     PIN_C_O,
    output logic                                     PIN_C_OE_O
);
    import tpu_cc_pkg::*;

    typedef struct packed {
        logic [7:0]             io_ctrl;
        logic                   buf_d;
        logic                   pwm1;
        logic [PSC_W-1:0]       psc;
        logic [15:0][CNT_W-1:0] gr;
        logic [CNT_W-1:0]       cnt0_prev;
        logic                   level;
        logic                   d_oe;
        logic                   c_oe;
        logic [15:0]            rdata;
    } core_state_type;

    localparam core_state_type S_RST = '{
        io_ctrl:   IO_RST,
        buf_d:     1'b0,
        pwm1:      1'b0,
        psc:       PSC_RST,
        gr:        {16{GR_RST}},
        cnt0_prev: CNT_RST,
        level:     1'b0,
        d_oe:      1'b0,
        c_oe:      1'b0,
        rdata:     16'h0000
    };

    core_state_type           s_reg;
    core_state_type           s_next;
    logic [CNT_W-1:0]         cnt [NUM_CH];
    logic [NUM_CH-1:0]        cnt_load;
    logic                     pin_rise;
    logic                     pin_fall;
    logic [3:0]               code;
    logic [3:0]               new_code;
    logic [1:0]               act;
    logic                     out_mode;
    logic                     match;
    logic                     pin_cap;
    logic                     ch1_cap;
    logic                     cap;
    logic [7:0]               rel_cnt;
    logic [7:0]               rel_gr;

    // per channel counters
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_cnt
            assign cnt_load[ch] = WR_I
                && (ADDR_I == OFS_CNT_BASE + 8'(ch));
            chan_counter #(
                .W (CNT_W)
            ) u_cnt (
                .clk_i      (SYS_CLK_I),
                .nrst_i     (NRST_I),
                .ce_i       (CE_I),
                .clear_i    (STANDBY_I),
                .load_i     (cnt_load[ch]),
                .load_val_i (WDATA_I),
                .tick_i     (COUNT_TICK_I[ch]),
                .down_i     (COUNT_DOWN_I[ch]),
                .cnt_o      (cnt[ch])
            );
        end
    endgenerate

    pin_edge u_edge (
        .clk_i  (SYS_CLK_I),
        .nrst_i (NRST_I),
        .ce_i   (CE_I),
        .pin_i  (PIN_D_I),
        .rise_o (pin_rise),
        .fall_o (pin_fall)
    );

    assign rel_cnt  = ADDR_I - OFS_CNT_BASE;
    assign rel_gr   = ADDR_I - OFS_GR_BASE;
    assign code     = s_reg.io_ctrl[IOD_HI:IOD_LO];
    assign act      = code[1:0];
    assign out_mode = !code[3];

    // compare match on a counter change into equality
    assign match = !s_reg.buf_d && out_mode
        && (cnt[0] == s_reg.gr[GR_D0])
        && (cnt[0] != s_reg.cnt0_prev);

    // capture sources
    always_comb begin
        pin_cap = 1'b0;
        if (code[3:2] == SRC_PIN) begin
            if (code[1]) begin
                pin_cap = pin_rise | pin_fall;
            end else if (code[0]) begin
                pin_cap = pin_fall;
            end else begin
                pin_cap = pin_rise;
            end
        end
    end

    assign ch1_cap = (code[3:2] == SRC_CH1) && COUNT_TICK_I[1]
        && (s_reg.psc != PSC_UNDIV);
    assign cap = !s_reg.buf_d && (pin_cap || ch1_cap);

    always_comb begin
        s_next       = s_reg;
        new_code     = 4'h0;
        s_next.rdata = 16'h0000;
        s_next.cnt0_prev = cnt[0];
        // compare output action
        if (match) begin
            case (act)
                ACT_LOW:  s_next.level = 1'b0;
                ACT_HIGH: s_next.level = 1'b1;
                ACT_TOG:  s_next.level = ~s_reg.level;
                default:  s_next.level = s_reg.level;
            endcase
        end
        // register writes
        if (WR_I) begin
            if (ADDR_I == OFS_IO_CTRL) begin
                s_next.io_ctrl = WDATA_I[7:0];
                if (!WDATA_I[IOD_CAP] && WDATA_I[IOD_LO+:2] != ACT_OFF) begin
                    s_next.level = WDATA_I[IOD_LVL];
                end
            end else if (ADDR_I == OFS_MODE) begin
                s_next.buf_d = WDATA_I[MODE_BUF_D];
                s_next.pwm1  = WDATA_I[MODE_PWM1];
            end else if (ADDR_I == OFS_CH1_CTRL) begin
                s_next.psc = WDATA_I[PSC_W-1:0];
            end else if (ADDR_I >= OFS_GR_BASE && ADDR_I < OFS_GR_END) begin
                s_next.gr[rel_gr[3:0]] = WDATA_I;
            end
        end
        // capture wins over a same-cycle bus write
        if (cap) begin
            s_next.gr[GR_D0] = cnt[0];
        end
        // pin routing
        new_code = s_next.io_ctrl[IOD_HI:IOD_LO];
        s_next.d_oe = !new_code[3] && new_code[1:0] != ACT_OFF
            && !s_next.pwm1;
        s_next.c_oe = !new_code[3] && new_code[1:0] != ACT_OFF
            && s_next.pwm1;
        // register reads, data one cycle later
        if (RD_I) begin
            if (ADDR_I == OFS_IO_CTRL) begin
                s_next.rdata = {8'h00, s_reg.io_ctrl};
            end else if (ADDR_I == OFS_MODE) begin
                s_next.rdata = {14'h0000, s_reg.pwm1, s_reg.buf_d};
            end else if (ADDR_I == OFS_CH1_CTRL) begin
                s_next.rdata = {13'h0000, s_reg.psc};
            end else if (ADDR_I == OFS_STATUS) begin
                s_next.rdata = {13'h0000, s_reg.c_oe, s_reg.d_oe,
                                s_reg.level};
            end else if (ADDR_I >= OFS_CNT_BASE && ADDR_I < OFS_CNT_END) begin
                s_next.rdata = cnt[rel_cnt[2:0]];
            end else if (ADDR_I >= OFS_GR_BASE && ADDR_I < OFS_GR_END) begin
                s_next.rdata = s_reg.gr[rel_gr[3:0]];
            end else begin
                s_next.rdata = 16'h0000;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            s_reg <= S_RST;
        end else if (CE_I) begin
            s_reg <= s_next;
        end
    end

    assign RDATA_O    = s_reg.rdata;
    assign PIN_D_O    = s_reg.level;
    assign PIN_D_OE_O = s_reg.d_oe;
    assign PIN_C_O    = s_reg.level;
    assign PIN_C_OE_O = s_reg.c_oe;

    // checks
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!NRST_I);

    logic wr_d0;
    logic wr_io;
    assign wr_d0 = WR_I && ADDR_I == OFS_GR_BASE + 8'(GR_D0);
    assign wr_io = WR_I && ADDR_I == OFS_IO_CTRL;

    sequence s_match(logic [1:0] a);
        CE_I && match && act == a && !wr_io;
    endsequence

    sequence s_pin_cap(logic [3:0] c, logic ev);
        CE_I && !s_reg.buf_d && code == c && ev;
    endsequence

    sequence s_took_count;
        s_reg.gr[GR_D0] == $past(cnt[0]);
    endsequence

    chk_drive_low: assert property (
        s_match(ACT_LOW) |=> !PIN_D_O)
        else $error("compare match did not drive pin low");
    chk_drive_high: assert property (
        s_match(ACT_HIGH) |=> PIN_D_O)
        else $error("compare match did not drive pin high");
    chk_toggle_out: assert property (
        s_match(ACT_TOG) |=> PIN_D_O != $past(PIN_D_O))
        else $error("compare match did not toggle pin");
    chk_off_no_drive: assert property (
        CE_I && !code[3] && act == ACT_OFF && !wr_io
        |=> !PIN_D_OE_O && !PIN_C_OE_O)
        else $error("disabled output still drives a pin");
    chk_initial_level: assert property (
        CE_I && wr_io && !WDATA_I[IOD_CAP]
        && WDATA_I[IOD_LO+:2] != ACT_OFF
        |=> PIN_D_O == $past(WDATA_I[IOD_LVL]))
        else $error("initial pin level not loaded");
    chk_rise_capture: assert property (
        s_pin_cap(4'h8, pin_rise) |=> s_took_count)
        else $error("rising edge capture missed");
    chk_rise_only: assert property (
        CE_I && code == 4'h8 && !pin_rise && !wr_d0
        |=> $stable(s_reg.gr[GR_D0]))
        else $error("capture taken without rising edge");
    chk_fall_capture: assert property (
        s_pin_cap(4'h9, pin_fall) |=> s_took_count)
        else $error("falling edge capture missed");
    chk_both_capture: assert property (
        CE_I && !s_reg.buf_d && code[3:1] == 3'b101
        && (pin_rise || pin_fall) |=> s_took_count)
        else $error("both-edge capture missed");
    chk_ch1_capture: assert property (
        CE_I && !s_reg.buf_d && code[3:2] == SRC_CH1
        && COUNT_TICK_I[1] && s_reg.psc != PSC_UNDIV |=> s_took_count)
        else $error("channel 1 count capture missed");
    chk_capture_no_drive: assert property (
        CE_I && code[3] && !wr_io |=> !PIN_D_OE_O && !PIN_C_OE_O)
        else $error("capture setting still drives a pin");
    chk_undiv_block: assert property (
        CE_I && code[3:2] == SRC_CH1 && s_reg.psc == PSC_UNDIV
        && !wr_d0 |=> $stable(s_reg.gr[GR_D0]))
        else $error("capture taken with undivided prescale");
    chk_buffer_hold: assert property (
        CE_I && s_reg.buf_d && !wr_d0 && !wr_io
        |=> $stable(s_reg.gr[GR_D0]) && $stable(PIN_D_O))
        else $error("buffer mode register or pin changed");
    chk_pwm_route: assert property (
        s_reg.pwm1 && !code[3] && act != ACT_OFF
        |-> PIN_C_OE_O && !PIN_D_OE_O)
        else $error("pwm mode 1 output not routed to pin c");
    chk_count_up: assert property (
        CE_I && COUNT_TICK_I[0] && !COUNT_DOWN_I[0] && !cnt_load[0]
        && !STANDBY_I |=> cnt[0] == $past(cnt[0]) + 16'h0001)
        else $error("channel 0 counter did not count up");
    chk_count_down: assert property (
        CE_I && COUNT_TICK_I[0] && COUNT_DOWN_I[0] && !cnt_load[0]
        && !STANDBY_I |=> cnt[0] == $past(cnt[0]) - 16'h0001)
        else $error("channel 0 counter did not count down");
    chk_count_load: assert property (
        CE_I && cnt_load[5] && !STANDBY_I |=> cnt[5] == $past(WDATA_I))
        else $error("counter write not loaded");
    chk_standby_clear: assert property (
        CE_I && STANDBY_I |=> cnt[0] == CNT_RST && cnt[5] == CNT_RST)
        else $error("standby did not clear counters");
    chk_read_answer: assert property (
        CE_I && RD_I && ADDR_I == OFS_MODE
        |=> RDATA_O == {14'h0000, $past(s_reg.pwm1), $past(s_reg.buf_d)})
        else $error("read data wrong one cycle after strobe");
    chk_read_idle: assert property (
        CE_I && !RD_I |=> RDATA_O == 16'h0000)
        else $error("read data not cleared after answer");
    chk_freeze_state: assert property (
        !CE_I |=> $stable(s_reg) && $stable(cnt[0]))
        else $error("state changed with clock enable low");
endmodule : timer_pulse_core
`default_nettype wire

// *** test/pin_partner.sv ***
// external pin model for channel 0 pin d
// assumes the bench sets the far-side level; design wins while enabled
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    // design side
    input  wire logic pin_lvl_i,
    input  wire logic pin_oe_i,
    // far side drive and wire
    input  wire logic ext_lvl_i,
    output logic      wire_o
);
    // wire level from the design enable alone, far side drives when design is off
    assign wire_o = pin_oe_i ? pin_lvl_i : ext_lvl_i;
endmodule : pin_partner
`default_nettype wire

// *** test/timer_pulse_unit_compare_capture_bench.sv ***
// self-checking bench for the timer compare/capture core
// assumes the core and its package are compiled first
`timescale 1ns/1ps
`default_nettype none
module timer_pulse_unit_compare_capture_bench;
    import tpu_cc_pkg::*;
    logic              clk;
    logic              nrst;
    logic              ce;
    logic              standby;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
    logic              wr;
    logic              rd;
    logic [15:0]       rdata;
    logic [NUM_CH-1:0] tick;
    logic [NUM_CH-1:0] down;
    logic              pin_wire;
    logic              ext_lvl;
    logic              pd_o;
    logic              pd_oe;
    logic              pc_o;
    logic              pc_oe;
    int                n_fail;
    int                n_tests;

    timer_pulse_core u_timer_pulse_core (
        .SYS_CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .STANDBY_I(standby),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .COUNT_TICK_I(tick), .COUNT_DOWN_I(down),
        .PIN_D_I(pin_wire), .PIN_D_O(pd_o), .PIN_D_OE_O(pd_oe),
        .PIN_C_O(pc_o), .PIN_C_OE_O(pc_oe)
    );
    pin_partner u_pin_partner (
        .pin_lvl_i(pd_o), .pin_oe_i(pd_oe), .ext_lvl_i(ext_lvl),
        .wire_o(pin_wire)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic summarize;
        $display("fails=%0d tests=%0d", n_fail, n_tests);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    // whole 16-bit bus cycles only
    task automatic wrr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wrr

    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk16(rdata, e);
    endtask : rdchk

    task automatic tk(input int ch, input logic dn);
        @(posedge clk);
        tick[ch] <= 1'b1;
        down[ch] <= dn;
        @(posedge clk);
        tick[ch] <= 1'b0;
    endtask : tk

    task automatic t_reset;
        for (int i = 0; i < NUM_CH; i++) begin
            rdchk(OFS_CNT_BASE + 8'(i), CNT_RST);
        end
        for (int i = 0; i < NUM_GR; i++) begin
            rdchk(OFS_GR_BASE + 8'(i), GR_RST);
        end
        rdchk(8'h40, 16'h0000);
        rdchk(OFS_IO_CTRL, {8'h00, IO_RST});
    endtask : t_reset

    task automatic t_regs;
        for (int i = 0; i < NUM_CH; i++) begin
            wrr(OFS_CNT_BASE + 8'(i), 16'h1000 + 16'(i));
        end
        for (int i = 0; i < NUM_CH; i++) begin
            rdchk(OFS_CNT_BASE + 8'(i), 16'h1000 + 16'(i));
        end
        for (int i = 0; i < NUM_GR; i++) begin
            wrr(OFS_GR_BASE + 8'(i), 16'ha000 + 16'(i));
        end
        for (int i = 0; i < NUM_GR; i++) begin
            rdchk(OFS_GR_BASE + 8'(i), 16'ha000 + 16'(i));
        end
        wrr(OFS_STATUS, 16'h0007);
        rdchk(OFS_STATUS, 16'h0000);
        tk(0, 1'b1);
        tk(5, 1'b0);
        rdchk(OFS_CNT_BASE, 16'h0fff);
        rdchk(OFS_CNT_BASE + 8'h05, 16'h1006);
        @(posedge clk);
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            rdchk(OFS_CNT_BASE + 8'(i), 16'h0000);
        end
    endtask : t_regs

    task automatic t_compare;
        logic [3:0] c;
        logic       oe;
        logic       lvl;
        for (int k = 1; k < 8; k++) begin
            c   = 4'(k);
            oe  = (c[1:0] != ACT_OFF);
            lvl = (c[1:0] == ACT_LOW) ? 1'b0 :
                  (c[1:0] == ACT_HIGH) ? 1'b1 : ~c[2];
            wrr(OFS_IO_CTRL, {8'h00, c, 4'h0});
            if (oe) begin
                rdchk(OFS_STATUS, {14'h0, 1'b1, c[2]});
            end
            wrr(OFS_GR_BASE + 8'(GR_D0), 16'h0010);
            wrr(OFS_CNT_BASE, 16'h000f);
            tk(0, 1'b0);
            @(posedge clk);
            #1;
            chk1(pd_oe, oe);
            if (oe) begin
                chk1(pd_o, lvl);
            end
        end
    endtask : t_compare

    task automatic t_capture;
        logic [3:0] c;
        for (int k = 8; k < 12; k++) begin
            c = 4'(k);
            wrr(OFS_IO_CTRL, {8'h00, c, 4'h0});
            wrr(OFS_GR_BASE + 8'(GR_D0), 16'hffff);
            wrr(OFS_CNT_BASE, 16'h0100 + 16'(k));
            ext_lvl <= 1'b1;
            repeat (3) @(posedge clk);
            rdchk(OFS_GR_BASE + 8'(GR_D0),
                  (c != 4'h9) ? 16'h0100 + 16'(k) : 16'hffff);
            wrr(OFS_GR_BASE + 8'(GR_D0), 16'hffff);
            wrr(OFS_CNT_BASE, 16'h0200 + 16'(k));
            ext_lvl <= 1'b0;
            repeat (3) @(posedge clk);
            rdchk(OFS_GR_BASE + 8'(GR_D0),
                  (c != 4'h8) ? 16'h0200 + 16'(k) : 16'hffff);
        end
    endtask : t_capture

    task automatic t_ch1;
        wrr(OFS_IO_CTRL, 16'h00c0);
        wrr(OFS_CH1_CTRL, 16'h0000);
        wrr(OFS_GR_BASE + 8'(GR_D0), 16'hffff);
        wrr(OFS_CNT_BASE, 16'h0333);
        tk(1, 1'b0);
        repeat (2) @(posedge clk);
        rdchk(OFS_GR_BASE + 8'(GR_D0), 16'hffff);
        wrr(OFS_CH1_CTRL, 16'h0001);
        tk(1, 1'b1);
        repeat (2) @(posedge clk);
        rdchk(OFS_GR_BASE + 8'(GR_D0), 16'h0333);
    endtask : t_ch1

    task automatic t_buffer;
        wrr(OFS_MODE, 16'h0001);
        wrr(OFS_IO_CTRL, 16'h0080);
        wrr(OFS_GR_BASE + 8'(GR_D0), 16'hffff);
        ext_lvl <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(OFS_GR_BASE + 8'(GR_D0), 16'hffff);
        wrr(OFS_IO_CTRL, 16'h0020);
        wrr(OFS_GR_BASE + 8'(GR_D0), 16'h0010);
        wrr(OFS_CNT_BASE, 16'h000f);
        tk(0, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        chk1(pd_o, 1'b0);
    endtask : t_buffer

    task automatic t_pwm;
        wrr(OFS_MODE, 16'h0002);
        wrr(OFS_IO_CTRL, 16'h0060);
        rdchk(OFS_STATUS, 16'h0005);
        chk1(pc_oe, 1'b1);
        chk1(pd_oe, 1'b0);
        chk1(pc_o, 1'b1);
    endtask : t_pwm

    task automatic t_enable;
        wrr(OFS_CNT_BASE, 16'h0050);
        @(posedge clk);
        ce      <= 1'b0;
        tick[0] <= 1'b1;
        down[0] <= 1'b0;
        @(posedge clk);
        ce      <= 1'b1;
        tick[0] <= 1'b0;
        rdchk(OFS_CNT_BASE, 16'h0050);
    endtask : t_enable

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end

    initial begin
        n_fail = 0;
        n_tests = 0;
        nrst = 1'b0;
        ce = 1'b1;
        standby = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        tick = '0;
        down = '0;
        ext_lvl = 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_regs();
        t_compare();
        t_capture();
        t_ch1();
        t_buffer();
        t_pwm();
        t_enable();
        summarize();
    end
endmodule : timer_pulse_unit_compare_capture_bench
`default_nettype wire
